// [bench/rtd_chk.sv]
/*
 * Port checker for the timekeeping value registers.
 * Assumes it is bound to the block from the bench top.
 */
`timescale 1ns/1ps
`default_nettype none
module rtd_chk #(
	parameter int OSC_FAIL_CYCLES = 64
) (
	// Clock and reset
	input wire logic               clock_i,
	input wire logic               reset_i,
	// Watched ports
	input wire logic [7:0]         reg_addr_i,
	input wire logic               reg_write_i,
	input wire logic [7:0]         reg_wdata_i,
	input wire logic               read_i,
	input wire logic [7:0]         read_data_o,
	input wire logic               osc_pin_i,
	input wire logic               midnight_tick_i,
	input wire logic               power_fail_event_i,
	input wire logic               osc_running_o,
	input wire logic               backup_supply_enable_o,
	input wire logic               timestamp_log_o,
	input wire rtd_pkg::rtd_time_t time_o
);
	// ****************************************
	// Helpers and assertions
	// ****************************************
	// Margin of 8 covers the pin synchroniser and the output register.
	int quiet;
	always_ff @(posedge clock_i) begin
		if (reset_i || osc_pin_i != $past(osc_pin_i))
			quiet <= 0;
		else if (quiet < 1000000)
			quiet <= quiet + 1;
	end
	function automatic logic [7:0] hv(input logic [7:0] w);
		return w[6] ? {2'h2 | {1'h0, w[5]}, 1'h0, w[4], w[3:0]} : {2'h0, w[5:4], w[3:0]};
	endfunction
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	a_minutes_digits: assert property (reg_write_i && reg_addr_i == 8'h01 ##1 !reg_write_i |=>
		{1'h0, time_o.minute_tens_digit, time_o.minute_ones_digit} == ($past(reg_wdata_i, 2) & 8'h7F))
		else $error("minutes decode wrong");
	a_hours_decode: assert property (reg_write_i && reg_addr_i == 8'h02 ##1 !reg_write_i |=>
		{time_o.twelve_hour, time_o.half_day_indicator, time_o.hour_tens_digit, time_o.hour_ones_digit}
		== hv($past(reg_wdata_i, 2))) else $error("hours decode wrong");
	a_day_digits: assert property (reg_write_i && reg_addr_i == 8'h04 ##1 !reg_write_i |=>
		{2'h0, time_o.day_tens_digit, time_o.day_ones_digit} == ($past(reg_wdata_i, 2) & 8'h3F))
		else $error("day decode wrong");
	a_unused_zero: assert property (read_i && reg_addr_i inside {[8'h01:8'h04]} |=>
		!read_data_o[7] && ($past(reg_addr_i) < 8'h03 || !read_data_o[6])) else $error("unused bit set");
	a_weekday_wrap: assert property (!reg_write_i && !midnight_tick_i ##1 midnight_tick_i && !reg_write_i
		##1 !midnight_tick_i && !reg_write_i |-> ##1 time_o.weekday_value
		== (($past(time_o.weekday_value, 2) == 3'h7) ? 3'h1 : $past(time_o.weekday_value, 2) + 3'h1))
		else $error("weekday step wrong");
	a_log_cause: assert property (timestamp_log_o |-> $past(power_fail_event_i))
		else $error("log without event");
	a_log_once: assert property (power_fail_event_i ##1 power_fail_event_i |=> !timestamp_log_o)
		else $error("log while flag set");
	a_osc_timeout: assert property (quiet > OSC_FAIL_CYCLES + 8 |-> !osc_running_o)
		else $error("running flag kept");
	a_backup_copy: assert property (reg_write_i && reg_addr_i == 8'h03 ##1 !reg_write_i |-> ##1
		backup_supply_enable_o == $past(reg_wdata_i[3], 2)) else $error("backup enable wrong");
endmodule
`default_nettype wire

// [bench/rtd_host.sv]
/*
 * Host model: the serial engine side of the byte register port.
 * Assumes the bench calls its tasks; signals change at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
module rtd_host (
	// Clock
	input  wire logic       clock_i,
	// Register port
	output var logic [7:0]  addr_o,
	output var logic        write_o,
	output var logic [7:0]  wdata_o,
	output var logic        start_o,
	output var logic        read_o,
	output var logic        stop_o,
	input  wire logic [7:0] data_i
);
	// ****************************************
	// Byte transfers
	// ****************************************
	initial begin
		addr_o = 8'h00;
		write_o = 1'h0;
		wdata_o = 8'h00;
		start_o = 1'h0;
		read_o = 1'h0;
		stop_o = 1'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_i);
		addr_o = a;
		wdata_o = d;
		write_o = 1'h1;
		@(negedge clock_i);
		write_o = 1'h0;
	endtask
	// Read data is taken a full cycle later, once the registered byte settled.
	task automatic rd(input logic [7:0] a, input logic first, output logic [7:0] d);
		@(negedge clock_i);
		addr_o = a;
		start_o = first;
		read_o = 1'h1;
		@(negedge clock_i);
		start_o = 1'h0;
		read_o = 1'h0;
		d = data_i;
	endtask
	task automatic stop();
		@(negedge clock_i);
		stop_o = 1'h1;
		@(negedge clock_i);
		stop_o = 1'h0;
	endtask
endmodule
`default_nettype wire

// [bench/rtd_time_date_registers_test.sv]
/*
 * Self-checking bench for the timekeeping value registers.
 * Assumes the package, the block, the host model and the checker.
 */
`timescale 1ns/1ps
`default_nettype none
module rtd_time_date_registers_test;
	// ****************************************
	// Set-up
	// ****************************************
	localparam int OSC_FAIL_CYCLES = 64;
	logic clock_i = 1'h0;
	logic reset_i = 1'h1;
	logic osc_pin = 1'h0;
	logic tick = 1'h0;
	logic pfail = 1'h0;
	logic [7:0] addr, wdata, rdata, d;
	logic wr_s, st_s, rd_s, sp_s, running, backup, logged, osc_en;
	rtd_pkg::rtd_time_t time_w;
	int err_total = 0;
	int check_count = 0;
	initial forever #2.5 clock_i = ~clock_i;
	rtd_host rtd_host_i (.clock_i(clock_i), .addr_o(addr), .write_o(wr_s), .wdata_o(wdata),
		.start_o(st_s), .read_o(rd_s), .stop_o(sp_s), .data_i(rdata));
	rtd_time_date_regs #(.OSC_FAIL_CYCLES(OSC_FAIL_CYCLES)) rtd_time_date_regs_i (.clock_i(clock_i),
		.reset_i(reset_i), .reg_addr_i(addr), .reg_write_i(wr_s), .reg_wdata_i(wdata),
		.read_start_i(st_s), .read_i(rd_s), .read_stop_i(sp_s), .read_data_o(rdata),
		.osc_pin_i(osc_pin), .midnight_tick_i(tick), .power_fail_event_i(pfail), .osc_enable_o(osc_en),
		.osc_running_o(running), .backup_supply_enable_o(backup), .timestamp_log_o(logged), .time_o(time_w));
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("Checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	function automatic logic [7:0] view(input logic [7:0] a);
		case (a)
		8'h01: return {1'h0, time_w.minute_tens_digit, time_w.minute_ones_digit};
		8'h02: return {time_w.twelve_hour, time_w.half_day_indicator, time_w.hour_tens_digit, time_w.hour_ones_digit};
		8'h03: return {5'h00, time_w.weekday_value};
		default: return {2'h0, time_w.day_tens_digit, time_w.day_ones_digit};
		endcase
	endfunction
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		logic [7:0] exp [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
		for (int a = 0; a < 6; a++) begin
			rtd_host_i.rd(8'(a), 1'h1, d);
			cmp(d, exp[a]);
		end
		cmp({7'h00, osc_en}, 8'h00);
		rtd_host_i.stop();
	endtask
	// Each entry: address, written byte, read back, decoded view.
	task automatic t_fields();
		logic [31:0] tab [10] = '{32'h01FF7F7F, 32'h02FF7FDF, 32'h04FF3F3F, 32'h03FF0F07, 32'h01595959,
			32'h027272D2, 32'h02525292, 32'h02232323, 32'h04313131, 32'h03010101};
		for (int i = 0; i < 10; i++) begin
			rtd_host_i.wr(tab[i][31:24], tab[i][23:16]);
			rtd_host_i.rd(tab[i][31:24], 1'h1, d);
			cmp(d, tab[i][15:8]);
			cmp(view(tab[i][31:24]), tab[i][7:0]);
			if (tab[i][31:24] == 8'h03)
				cmp({7'h00, backup}, {7'h00, tab[i][19]});
		end
		rtd_host_i.wr(8'h00, 8'hA5);
		rtd_host_i.rd(8'h00, 1'h1, d);
		cmp(d, 8'hA5);
		cmp({7'h00, osc_en}, 8'h01);
		rtd_host_i.stop();
	endtask
	task automatic t_buffer();
		rtd_host_i.wr(8'h01, 8'h12);
		rtd_host_i.rd(8'h00, 1'h1, d);
		rtd_host_i.wr(8'h01, 8'h34);
		rtd_host_i.rd(8'h01, 1'h0, d);
		cmp(d, 8'h12);
		rtd_host_i.rd(8'h1F, 1'h0, d);
		rtd_host_i.rd(8'h00, 1'h0, d);
		rtd_host_i.rd(8'h01, 1'h0, d);
		cmp(d, 8'h34);
		rtd_host_i.stop();
	endtask
	task automatic t_midnight();
		rtd_host_i.wr(8'h03, 8'h07);
		for (int i = 1; i < 3; i++) begin
			@(negedge clock_i) tick = 1'h1;
			@(negedge clock_i) tick = 1'h0;
			rtd_host_i.rd(8'h03, 1'h1, d);
			cmp(d, 8'(i));
		end
		rtd_host_i.stop();
	endtask
	task automatic ev(input int n, input logic [7:0] pulses, input logic [7:0] flag);
		int seen = 0;
		@(negedge clock_i) pfail = 1'h1;
		repeat (n) @(negedge clock_i) seen += int'(logged);
		pfail = 1'h0;
		repeat (2) @(negedge clock_i) seen += int'(logged);
		cmp(8'(seen), pulses);
		rtd_host_i.rd(8'h03, 1'h1, d);
		cmp(d & 8'h10, flag);
		rtd_host_i.stop();
	endtask
	task automatic t_power();
		ev(2, 8'h01, 8'h10);
		ev(1, 8'h00, 8'h10);
		rtd_host_i.wr(8'h03, 8'h11);
		rtd_host_i.rd(8'h03, 1'h1, d);
		cmp(d, 8'h01);
		ev(1, 8'h01, 8'h10);
	endtask
	// Half period of 8 cycles leaves room for the pin synchroniser.
	task automatic t_osc();
		for (int i = 1; i < 33; i++) begin
			repeat (8) @(negedge clock_i) osc_pin = 1'h1;
			repeat (8) @(negedge clock_i) osc_pin = 1'h0;
			cmp({7'h00, running}, {7'h00, i == 32});
		end
		rtd_host_i.rd(8'h03, 1'h1, d);
		cmp(d & 8'h20, 8'h20);
		repeat (OSC_FAIL_CYCLES + 10) @(negedge clock_i);
		cmp({7'h00, running}, 8'h00);
	endtask
	initial begin
		repeat (8) @(negedge clock_i);
		reset_i = 1'h0;
		t_reset();
		t_fields();
		t_buffer();
		t_midnight();
		t_power();
		t_osc();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		err_total++;
		close_out();
	end
endmodule
bind rtd_time_date_regs rtd_chk #(.OSC_FAIL_CYCLES(OSC_FAIL_CYCLES)) rtd_chk_i (.clock_i, .reset_i,
	.reg_addr_i, .reg_write_i, .reg_wdata_i, .read_i, .read_data_o, .osc_pin_i, .midnight_tick_i,
	.power_fail_event_i, .osc_running_o, .backup_supply_enable_o, .timestamp_log_o, .time_o);
`default_nettype wire

// [src/rtd_pkg.sv]
/*
 * Package for the timekeeping value registers: offsets, field positions,
 * reset values, timing figures and the carrier structs.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rtd_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] SECONDS_VALUE_ADDR      = 8'h00;
	localparam logic [7:0] MINUTES_VALUE_ADDR      = 8'h01;
	localparam logic [7:0] HOURS_VALUE_ADDR        = 8'h02;
	localparam logic [7:0] WEEKDAY_AND_STATUS_ADDR = 8'h03;
	localparam logic [7:0] DAY_OF_MONTH_VALUE_ADDR = 8'h04;
	localparam logic [7:0] CLOCK_RANGE_FIRST       = 8'h00;
	localparam logic [7:0] CLOCK_RANGE_LAST        = 8'h1F;

	// ************************************************************
	// Field masks and positions
	// ************************************************************
	localparam logic [7:0] MINUTES_WRITE_MASK = 8'h7F;
	localparam logic [7:0] HOURS_WRITE_MASK   = 8'h7F;
	localparam logic [7:0] DAY_WRITE_MASK     = 8'h3F;
	localparam int         HOUR_FORMAT_BIT    = 6;
	localparam int         HALF_DAY_BIT       = 5;
	localparam int         HOUR_TENS_LOW_BIT  = 4;
	localparam int         OSC_RUNNING_BIT    = 5;
	localparam int         POWER_LOSS_BIT     = 4;
	localparam int         BACKUP_ENABLE_BIT  = 3;
	localparam int         OSC_START_BIT      = 7;
	localparam int         MINUTE_TENS_HIGH_BIT = 6;
	localparam int         DAY_TENS_HIGH_BIT    = 5;
	localparam int         TENS_LOW_BIT         = 4;
	localparam int         ONES_HIGH_BIT        = 3;
	localparam int         ONES_LOW_BIT         = 0;
	localparam int         WEEKDAY_HIGH_BIT     = 2;

	// ************************************************************
	// Reset values and digit limits
	// ************************************************************
	localparam logic [7:0] SECONDS_RESET      = 8'h00;
	localparam logic [7:0] MINUTES_RESET      = 8'h00;
	localparam logic [7:0] HOURS_RESET        = 8'h00;
	localparam logic [7:0] DAY_RESET          = 8'h01;
	localparam logic [2:0] WEEKDAY_FIRST      = 3'h1;
	localparam logic [2:0] WEEKDAY_LAST       = 3'h7;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int          CLOCK_PERIOD_PS   = 5000;
	localparam int          OSC_START_EDGES   = 32;
	localparam logic [5:0]  OSC_START_COUNT   = 6'(OSC_START_EDGES);
	localparam int          OSC_FAIL_TIME_US  = 1000;
	localparam int          OSC_FAIL_CYCLES   = (OSC_FAIL_TIME_US * 1000000) / CLOCK_PERIOD_PS;
	localparam int          FAIL_COUNT_WIDTH  = 24;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic [7:0] seconds;
		logic [7:0] minutes;
		logic [7:0] hours;
		logic [7:0] weekday;
		logic [7:0] day;
	} rtd_regs_t;

	typedef struct packed {
		logic       twelve_hour;
		logic       half_day_indicator;
		logic [1:0] hour_tens_digit;
		logic [3:0] hour_ones_digit;
		logic [2:0] minute_tens_digit;
		logic [3:0] minute_ones_digit;
		logic [1:0] day_tens_digit;
		logic [3:0] day_ones_digit;
		logic [2:0] weekday_value;
	} rtd_time_t;

endpackage

// [src/rtd_time_date_regs.sv]
/*
 * Timekeeping value registers (seconds, minutes, hours, weekday with
 * status, day of month) with the read buffer, oscillator status and
 * power-loss flag.
 * Assumes a serial bus engine in front that hands over byte accesses
 * with their address, marks the start and end of each read operation,
 * and a counter chain that pulses at midnight.
 */
// Notes on behaviour
// - Minutes bits 6..4 hold the BCD tens digit, zero to five.
// - Minutes bits 3..0 hold the BCD ones digit, zero to nine.
// - Unused top bits of minutes, hours, weekday and day always read zero.
// - Hours bit 6 picks twelve-hour when one, twenty-four-hour when zero.
// - In twelve-hour mode hours bit 5 is one for PM, zero for AM.
// - In twelve-hour mode the hour tens digit is bit 4 only, zero or one.
// - In twenty-four-hour mode hour tens is bits 5..4, zero to two.
// - Hour ones digit sits in bits 3..0 in either format.
// - Day bits 5..4 hold the BCD tens digit, zero to three.
// - Day bits 3..0 hold the BCD ones digit, zero to nine.
// - Oscillator-running flag sets after 32 rising oscillator edges, clears after the failure timeout.
// - Weekday counts one to seven, advances at midnight, wraps seven to one.
// - Reads see a buffer refreshed at read start and on range wrap.
`timescale 1ns/1ps
`default_nettype none

module rtd_time_date_regs #(
	parameter int OSC_FAIL_CYCLES = rtd_pkg::OSC_FAIL_CYCLES
) (
	// Clock and reset
	input  wire logic            clock_i,
	input  wire logic            reset_i,
	// Byte register port from the serial engine
	input  wire logic [7:0]      reg_addr_i,
	input  wire logic            reg_write_i,
	input  wire logic [7:0]      reg_wdata_i,
	input  wire logic            read_start_i,
	input  wire logic            read_i,
	input  wire logic            read_stop_i,
	output logic      [7:0]      read_data_o,
	// Events from the rest of the clock
	input  wire logic            osc_pin_i,
	input  wire logic            midnight_tick_i,
	input  wire logic            power_fail_event_i,
	// Status and control outputs
	output logic                 osc_enable_o,
	output logic                 osc_running_o,
	output logic                 backup_supply_enable_o,
	output logic                 timestamp_log_o,
	output rtd_pkg::rtd_time_t   time_o
);

	// ************************************************************
	// Register state
	// ************************************************************
	rtd_pkg::rtd_regs_t                          live;
	rtd_pkg::rtd_regs_t                          snapshot;
	logic [2:0]                                  weekday_value;
	logic                                        backup_supply_enable;
	logic                                        power_loss_flag;
	logic                                        osc_running_flag;
	logic [2:0]                                  osc_sync;
	logic [5:0]                                  osc_edges;
	logic [rtd_pkg::FAIL_COUNT_WIDTH-1:0]        osc_idle;
	logic                                        read_active;
	logic                                        last_read_top;
	logic                                        refresh_now;
	logic                                        osc_edge;
	logic [7:0]                                  next_read_data;
	rtd_pkg::rtd_regs_t                          read_source;

	localparam logic [rtd_pkg::FAIL_COUNT_WIDTH-1:0] FAIL_LIMIT =
		rtd_pkg::FAIL_COUNT_WIDTH'(OSC_FAIL_CYCLES);

	wire wr_sec  = reg_write_i && (reg_addr_i == rtd_pkg::SECONDS_VALUE_ADDR);
	wire wr_min  = reg_write_i && (reg_addr_i == rtd_pkg::MINUTES_VALUE_ADDR);
	wire wr_hour = reg_write_i && (reg_addr_i == rtd_pkg::HOURS_VALUE_ADDR);
	wire wr_wday = reg_write_i && (reg_addr_i == rtd_pkg::WEEKDAY_AND_STATUS_ADDR);
	wire wr_day  = reg_write_i && (reg_addr_i == rtd_pkg::DAY_OF_MONTH_VALUE_ADDR);

	// ************************************************************
	// Value registers
	// ************************************************************
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			live.seconds <= rtd_pkg::SECONDS_RESET;
			live.minutes <= rtd_pkg::MINUTES_RESET;
			live.hours   <= rtd_pkg::HOURS_RESET;
			live.day     <= rtd_pkg::DAY_RESET;
			// The weekday byte is composed from its own registers, so this slot only holds zero.
			live.weekday <= '0;
		end else begin
			if (wr_sec) begin
				live.seconds <= reg_wdata_i;
			end
			if (wr_min) begin
				live.minutes <= reg_wdata_i & rtd_pkg::MINUTES_WRITE_MASK;
			end
			if (wr_hour) begin
				live.hours <= reg_wdata_i & rtd_pkg::HOURS_WRITE_MASK;
			end
			if (wr_day) begin
				live.day <= reg_wdata_i & rtd_pkg::DAY_WRITE_MASK;
			end
		end
	end

	// ************************************************************
	// Weekday field and backup enable
	// ************************************************************
	// A write in the midnight cycle wins, so software always sees its own value.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			weekday_value <= rtd_pkg::WEEKDAY_FIRST;
		end else if (wr_wday) begin
			weekday_value <= reg_wdata_i[rtd_pkg::WEEKDAY_HIGH_BIT:rtd_pkg::ONES_LOW_BIT];
		end else if (midnight_tick_i) begin
			if (weekday_value == rtd_pkg::WEEKDAY_LAST) begin
				weekday_value <= rtd_pkg::WEEKDAY_FIRST;
			end else begin
				weekday_value <= weekday_value + 3'h1;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			backup_supply_enable <= 1'b0;
		end else if (wr_wday) begin
			backup_supply_enable <= reg_wdata_i[rtd_pkg::BACKUP_ENABLE_BIT];
		end
	end

	// ************************************************************
	// Power-loss flag
	// ************************************************************
	// The set wins over a clearing write so a failure is never missed.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			power_loss_flag <= 1'b0;
			timestamp_log_o <= 1'b0;
		end else begin
			timestamp_log_o <= power_fail_event_i && !power_loss_flag;
			if (power_fail_event_i) begin
				power_loss_flag <= 1'b1;
			end else if (wr_wday) begin
				power_loss_flag <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Oscillator status
	// ************************************************************
	// Three stages: only the second and third are compared for an edge.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			osc_sync <= 3'h0;
		end else begin
			osc_sync <= {osc_sync[1:0], osc_pin_i};
		end
	end

	assign osc_edge = osc_sync[1] && !osc_sync[2];

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			osc_edges        <= 6'h00;
			osc_idle         <= '0;
			osc_running_flag <= 1'b0;
		end else if (osc_edge) begin
			osc_idle <= '0;
			if (osc_edges != rtd_pkg::OSC_START_COUNT) begin
				osc_edges <= osc_edges + 6'h01;
			end
			if (osc_edges == rtd_pkg::OSC_START_COUNT - 6'h01) begin
				osc_running_flag <= 1'b1;
			end
		end else if (osc_idle >= FAIL_LIMIT) begin
			osc_running_flag <= 1'b0;
			osc_edges        <= 6'h00;
		end else begin
			osc_idle <= osc_idle + rtd_pkg::FAIL_COUNT_WIDTH'(1);
		end
	end

	// ************************************************************
	// Read buffer
	// ************************************************************
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			read_active   <= 1'b0;
			last_read_top <= 1'b0;
		end else begin
			if (read_start_i) begin
				read_active <= 1'b1;
			end else if (read_stop_i) begin
				read_active <= 1'b0;
			end
			if (read_start_i || read_stop_i) begin
				last_read_top <= 1'b0;
			end else if (read_i) begin
				last_read_top <= (reg_addr_i == rtd_pkg::CLOCK_RANGE_LAST);
			end
		end
	end

	assign refresh_now = read_start_i
		|| (read_i && read_active && last_read_top
		&& (reg_addr_i == rtd_pkg::CLOCK_RANGE_FIRST));

	always_comb begin
		read_source = live;
		read_source.weekday = {2'b00, osc_running_flag, power_loss_flag, backup_supply_enable,
			weekday_value};
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			snapshot <= '0;
		end else if (refresh_now) begin
			snapshot <= read_source;
		end
	end

	// A read in the refresh cycle is served from the live values it captures.
	always_comb begin
		rtd_pkg::rtd_regs_t src;
		src = refresh_now ? read_source : snapshot;
		next_read_data = 8'h00;
		if (reg_addr_i == rtd_pkg::SECONDS_VALUE_ADDR) begin
			next_read_data = src.seconds;
		end else if (reg_addr_i == rtd_pkg::MINUTES_VALUE_ADDR) begin
			next_read_data = src.minutes;
		end else if (reg_addr_i == rtd_pkg::HOURS_VALUE_ADDR) begin
			next_read_data = src.hours;
		end else if (reg_addr_i == rtd_pkg::WEEKDAY_AND_STATUS_ADDR) begin
			next_read_data = src.weekday;
		end else if (reg_addr_i == rtd_pkg::DAY_OF_MONTH_VALUE_ADDR) begin
			next_read_data = src.day;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			read_data_o <= 8'h00;
		end else if (read_i) begin
			read_data_o <= next_read_data;
		end
	end

	// ************************************************************
	// Decoded outputs
	// ************************************************************
	// The decode follows the live values, not the read buffer, so it lags a write by one cycle.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			time_o <= '0;
		end else begin
			time_o.twelve_hour <= live.hours[rtd_pkg::HOUR_FORMAT_BIT];
			if (live.hours[rtd_pkg::HOUR_FORMAT_BIT]) begin
				time_o.half_day_indicator <= live.hours[rtd_pkg::HALF_DAY_BIT];
				time_o.hour_tens_digit    <= {1'b0, live.hours[rtd_pkg::HOUR_TENS_LOW_BIT]};
			end else begin
				time_o.half_day_indicator <= 1'b0;
				time_o.hour_tens_digit    <= live.hours[rtd_pkg::HALF_DAY_BIT:rtd_pkg::HOUR_TENS_LOW_BIT];
			end
			time_o.hour_ones_digit   <= live.hours[rtd_pkg::ONES_HIGH_BIT:rtd_pkg::ONES_LOW_BIT];
			time_o.minute_tens_digit <= live.minutes[rtd_pkg::MINUTE_TENS_HIGH_BIT:rtd_pkg::TENS_LOW_BIT];
			time_o.minute_ones_digit <= live.minutes[rtd_pkg::ONES_HIGH_BIT:rtd_pkg::ONES_LOW_BIT];
			time_o.day_tens_digit    <= live.day[rtd_pkg::DAY_TENS_HIGH_BIT:rtd_pkg::TENS_LOW_BIT];
			time_o.day_ones_digit    <= live.day[rtd_pkg::ONES_HIGH_BIT:rtd_pkg::ONES_LOW_BIT];
			time_o.weekday_value     <= weekday_value;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			osc_enable_o <= 1'b0;
		end else begin
			osc_enable_o <= live.seconds[rtd_pkg::OSC_START_BIT];
		end
	end

	// A user sees the running flag one cycle after it changes, which keeps the output glitch free.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			osc_running_o <= 1'b0;
		end else begin
			osc_running_o <= osc_running_flag;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			backup_supply_enable_o <= 1'b0;
		end else begin
			backup_supply_enable_o <= backup_supply_enable;
		end
	end

endmodule

`default_nettype wire
